// File: shared/bmw_pkg.sv
// Purpose: shared types and constants for the brown-out mode and warning control
// Assumes: one 125 MHz clock, fuse values valid while reset is held
// Notes: mode and trigger encodings follow the detector field layout
`default_nettype none
package bmw_pkg;

  localparam logic [1:0] BMW_MODE_DIS = 2'h0;
  localparam logic [1:0] BMW_MODE_CONT = 2'h1;
  localparam logic [1:0] BMW_MODE_SAMP = 2'h2;
  localparam logic [1:0] BMW_MODE_HOLD = 2'h3;

  localparam logic [1:0] BMW_TRIG_BELOW = 2'h0;
  localparam logic [1:0] BMW_TRIG_ABOVE = 2'h1;
  localparam logic [1:0] BMW_TRIG_CROSS = 2'h2;

  localparam logic [1:0] BMW_MARGIN_RST = 2'h0;
  localparam logic [1:0] BMW_TRIG_RST = 2'h0;
  localparam logic [2:0] BMW_KEY_WINDOW = 3'h4;
  localparam logic [7:0] BMW_UNLOCK_KEY = 8'hD8;

  localparam int BMW_CLK_HZ = 125000000;
  localparam int BMW_SAMP_FAST_HZ = 1000;
  localparam int BMW_SAMP_SLOW_HZ = 125;
  localparam int BMW_SAMP_FAST_CYC = BMW_CLK_HZ / BMW_SAMP_FAST_HZ;
  localparam int BMW_SAMP_SLOW_CYC = BMW_CLK_HZ / BMW_SAMP_SLOW_HZ;

  typedef struct packed {
    logic [2:0] level;
    logic samp_slow;
    logic [1:0] awake_mode;
    logic [1:0] lowpower_mode;
  } bmw_fuse_t;

  typedef struct packed {
    logic [1:0] margin;
    logic [1:0] trig;
    logic irq_en;
  } bmw_warn_cfg_t;

endpackage

`default_nettype wire

// File: rtl/bmw_ctrl.sv
// Purpose: mode control of the supply drop detector and its early warning monitor
// Assumes: comparator outputs synchronous to clk_i; sleep_i high during standby/power-down
// Notes: sample period counts are parameters so simulation can shorten them
`timescale 1ns/1ns
`default_nettype none

// Functional notes
// - request system reset while enabled detector sees supply below drop threshold.
// - warning comparator threshold sits a chosen margin above the drop threshold.
// - detector runs continuously or is strobed once per sample period.
// - fuse values load threshold, awake mode and sleep mode during reset.
// - threshold and awake mode are read only; only reset loads them.
// - software may rewrite the low power mode field during operation.
// - warning monitor evaluates crossings once software sets the enable bit.
// - warning events qualified as below, above or either direction crossing.
// - warning monitor stays inactive whenever the detector is disabled.
// - in sampled mode warning is evaluated only at sample instants.
// - enabled warning sets the flag on a crossing in the chosen direction.
// - warning threshold derived from margin select relative to drop threshold.
// - warning interrupt request is held off while the processor is halted.
// - interrupt request asserted while enable and flag both set and the processor is not halted.
// - entering standby or power down applies the low power mode.
// - waking returns the detector to the awake mode.
// - key write opens a four instruction window for the protected field.
// - protected field writes outside an open window are ignored.
// - modes 0 off, 1 continuous, 2 sampled, 3 continuous with wake hold.
// - trigger codes 0 below, 1 above, 2 either; others reserved.
// - warning flag sets only while detector enabled, otherwise held unless software clears it.
// - warning state reads one when supply is below warning level.
module bmw_ctrl #(
  parameter int SAMP_FAST_CYC = bmw_pkg::BMW_SAMP_FAST_CYC,
  parameter int SAMP_SLOW_CYC = bmw_pkg::BMW_SAMP_SLOW_CYC
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // fuse settings
  input wire bmw_pkg::bmw_fuse_t fuse_i,
  // power state and debug
  input wire logic sleep_i,
  input wire logic dbg_halt_i,
  // unlock key path
  input wire logic key_wr_i,
  input wire logic [7:0] key_data_i,
  input wire logic instr_i,
  // software writes
  input wire logic lp_mode_wr_i,
  input wire logic [1:0] lp_mode_data_i,
  input wire logic samp_wr_i,
  input wire logic samp_data_i,
  input wire logic cfg_wr_i,
  input wire bmw_pkg::bmw_warn_cfg_t cfg_data_i,
  input wire logic flag_clr_i,
  // analog comparators
  input wire logic drop_below_i,
  input wire logic warn_below_i,
  // analog controls
  output logic det_on_o,
  output logic [2:0] det_level_o,
  output logic [1:0] warn_margin_o,
  output logic wake_hold_o,
  // status and requests
  output logic reset_req_o,
  output logic [1:0] awake_mode_o,
  output logic [1:0] lowpower_mode_o,
  output logic samp_slow_o,
  output bmw_pkg::bmw_warn_cfg_t cfg_o,
  output logic warning_flag_o,
  output logic warning_state_o,
  output logic irq_o
);

  logic [1:0] awake_mode;
  logic [1:0] lowpower_mode;
  logic [2:0] level;
  logic samp_slow;
  bmw_pkg::bmw_warn_cfg_t cfg;
  logic [2:0] key_left;
  logic [23:0] samp_cnt;
  logic warn_state;
  logic warn_valid;
  logic flag;
  logic wake_hold;
  logic sleep_d;
  logic [1:0] cur_mode;
  logic det_en;
  logic sample_tick;
  logic eval;
  logic rise;
  logic fall;
  logic hit;
  logic [23:0] samp_top;

  assign cur_mode = sleep_i ? lowpower_mode : awake_mode;
  assign det_en = (cur_mode != bmw_pkg::BMW_MODE_DIS);
  assign samp_top = samp_slow ? 24'(SAMP_SLOW_CYC - 1) : 24'(SAMP_FAST_CYC - 1);
  // >= so a switch to the shorter period never runs the counter past its top
  assign sample_tick = (samp_cnt >= samp_top);

  assign eval = det_en && cfg.irq_en && ((cur_mode != bmw_pkg::BMW_MODE_SAMP) || sample_tick);
  // first sample after enable only records the level, junk never reaches the flag
  assign fall = warn_valid && !warn_state && warn_below_i;
  assign rise = warn_valid && warn_state && !warn_below_i;

  always_comb begin
    case (cfg.trig)
      bmw_pkg::BMW_TRIG_BELOW: hit = fall;
      bmw_pkg::BMW_TRIG_ABOVE: hit = rise;
      bmw_pkg::BMW_TRIG_CROSS: hit = fall || rise;
      default: hit = 1'b0;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      level <= fuse_i.level;
      awake_mode <= fuse_i.awake_mode;
    end
  end

  // a wrong key leaves an open window alone
  // four instruction window
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      key_left <= 3'h0;
    end else if (key_wr_i && key_data_i == bmw_pkg::BMW_UNLOCK_KEY) begin
      key_left <= bmw_pkg::BMW_KEY_WINDOW;
    end else if (lp_mode_wr_i) begin
      key_left <= 3'h0;
    end else if (instr_i && key_left != 3'h0) begin
      key_left <= key_left - 3'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      lowpower_mode <= fuse_i.lowpower_mode;
    end else if (lp_mode_wr_i && key_left != 3'h0) begin
      lowpower_mode <= lp_mode_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      samp_slow <= fuse_i.samp_slow;
      cfg <= '{margin: bmw_pkg::BMW_MARGIN_RST, trig: bmw_pkg::BMW_TRIG_RST, irq_en: 1'b0};
    end else begin
      if (samp_wr_i) begin
        samp_slow <= samp_data_i;
      end
      if (cfg_wr_i) begin
        cfg <= cfg_data_i;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i || cur_mode != bmw_pkg::BMW_MODE_SAMP || sample_tick) begin
      samp_cnt <= 24'h0;
    end else begin
      samp_cnt <= samp_cnt + 24'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      warn_state <= 1'b0;
      warn_valid <= 1'b0;
    end else if (!det_en) begin
      warn_valid <= 1'b0;
    end else if (eval || (det_en && (cur_mode != bmw_pkg::BMW_MODE_SAMP || sample_tick))) begin
      warn_state <= warn_below_i;
      warn_valid <= 1'b1;
    end
  end

  // set on crossing, set beats clear
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      flag <= 1'b0;
    end else if (eval && hit) begin
      flag <= 1'b1;
    end else if (flag_clr_i) begin
      flag <= 1'b0;
    end
  end

  // hold execution on wake until running
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      sleep_d <= 1'b0;
      wake_hold <= 1'b0;
    end else begin
      sleep_d <= sleep_i;
      wake_hold <= sleep_d && !sleep_i && awake_mode == bmw_pkg::BMW_MODE_HOLD;
    end
  end

  assign reset_req_o = det_on_o && drop_below_i;
  assign det_on_o = det_en && ((cur_mode != bmw_pkg::BMW_MODE_SAMP) || sample_tick);
  assign det_level_o = level;
  assign warn_margin_o = cfg.margin;
  assign wake_hold_o = wake_hold;
  assign awake_mode_o = awake_mode;
  assign lowpower_mode_o = lowpower_mode;
  assign samp_slow_o = samp_slow;
  assign cfg_o = cfg;
  assign warning_flag_o = flag;
  assign warning_state_o = warn_state;
  assign irq_o = cfg.irq_en && flag && !dbg_halt_i;

  // irq path
  AST_IRQ_EQ: assert property (@(posedge clk_i) disable iff (!nrst_i)
    irq_o == (cfg.irq_en && flag && !dbg_halt_i))
    else $error("irq mismatch");
  AST_DBG: assert property (@(posedge clk_i) disable iff (!nrst_i)
    dbg_halt_i |-> !irq_o)
    else $error("irq during debug halt");

  // unlock, protected field and read only fields
  AST_LOCK: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (lp_mode_wr_i && key_left == 3'h0) |=> $stable(lowpower_mode))
    else $error("locked write took");
  AST_LP_TAKE: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (lp_mode_wr_i && key_left != 3'h0) |=> lowpower_mode == $past(lp_mode_data_i))
    else $error("unlocked write lost");
  AST_KEY_OPEN: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (key_wr_i && key_data_i == bmw_pkg::BMW_UNLOCK_KEY) |=> key_left == bmw_pkg::BMW_KEY_WINDOW)
    else $error("key did not open window");
  AST_WIN: assert property (@(posedge clk_i) disable iff (!nrst_i)
    key_left <= bmw_pkg::BMW_KEY_WINDOW)
    else $error("window overrun");
  AST_RO: assert property (@(posedge clk_i) disable iff (!nrst_i)
    ##1 $stable(level) && $stable(awake_mode))
    else $error("read only field moved");

  // warning flag and status
  AST_HOLD: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (!det_en && !flag_clr_i) |=> $stable(flag))
    else $error("flag moved while disabled");
  AST_SET: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (eval && hit) |=> flag)
    else $error("flag not set");
  AST_CLR: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (flag_clr_i && !(eval && hit)) |=> !flag)
    else $error("flag not cleared");
  AST_SAMP_EVAL: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (cur_mode == bmw_pkg::BMW_MODE_SAMP && !sample_tick && !flag_clr_i) |=> $stable(flag))
    else $error("flag moved between samples");
  AST_OFF: assert property (@(posedge clk_i) disable iff (!nrst_i)
    !det_en |=> !warn_valid)
    else $error("monitor live while detector off");
  AST_WARN_STATE: assert property (@(posedge clk_i) disable iff (!nrst_i)
    det_on_o |=> warning_state_o == $past(warn_below_i))
    else $error("warning state not tracked");

  // detector power and modes
  AST_RST: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (cur_mode == bmw_pkg::BMW_MODE_DIS) |-> !reset_req_o)
    else $error("reset while disabled");
  AST_MODE: assert property (@(posedge clk_i) disable iff (!nrst_i)
    sleep_i |-> det_en == (lowpower_mode != bmw_pkg::BMW_MODE_DIS))
    else $error("sleep mode wrong");
  AST_SAMP_GAP: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (cur_mode == bmw_pkg::BMW_MODE_SAMP && det_on_o) ##1 (cur_mode == bmw_pkg::BMW_MODE_SAMP) |-> !det_on_o)
    else $error("sampled detector stayed on");
  AST_WAKE: assert property (@(posedge clk_i) disable iff (!nrst_i)
    wake_hold |-> (awake_mode == bmw_pkg::BMW_MODE_HOLD) && !$past(sleep_i) && $past(sleep_i, 2))
    else $error("wake hold without wake");

  // main scenarios reached
  COV_UNLOCK: cover property (@(posedge clk_i) disable iff (!nrst_i) lp_mode_wr_i && key_left != 3'h0);
  COV_FLAG: cover property (@(posedge clk_i) disable iff (!nrst_i) !flag ##1 flag);
  COV_SAMP: cover property (@(posedge clk_i) disable iff (!nrst_i) cur_mode == bmw_pkg::BMW_MODE_SAMP && sample_tick);
  COV_WAKE: cover property (@(posedge clk_i) disable iff (!nrst_i) wake_hold);
  COV_HALT: cover property (@(posedge clk_i) disable iff (!nrst_i) dbg_halt_i && flag && cfg.irq_en);

endmodule

`default_nettype wire

// File: sim/bmw_supply_model.sv
// Purpose: behavioural supply comparators facing the detector control
// Assumes: supply given as a plain code on vdd_i, larger means higher voltage
// Notes: an unpowered comparator gives junk that changes every cycle
`timescale 1ns/1ns
`default_nettype none
module bmw_supply_model #(
  parameter logic [7:0] DROP_CODE = 8'h64,
  parameter logic [7:0] WARN_CODE = 8'h96
) (
  // clock
  input wire logic clk_i,
  // detector side
  input wire logic det_on_i,
  input wire logic [7:0] vdd_i,
  output logic drop_below_o,
  output logic warn_below_o
);
  logic junk = 1'b0;
  always_ff @(posedge clk_i) begin
    junk <= ~junk;
  end
  assign drop_below_o = det_on_i ? (vdd_i < DROP_CODE) : junk;
  assign warn_below_o = det_on_i ? (vdd_i < WARN_CODE) : ~junk;
endmodule
`default_nettype wire

// File: sim/bmw_ctrl_tb.sv
// Purpose: self-checking bench for the detector mode and warning control
// Assumes: sample periods shortened to 8 and 16 cycles
// Notes: all stimulus changes at the falling clock edge
`timescale 1ns/1ns
`default_nettype none
module bmw_ctrl_tb;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  bmw_pkg::bmw_fuse_t fuse_i = 8'hA4;
  logic sleep_i = 1'b0, dbg_halt_i = 1'b0, key_wr_i = 1'b0, instr_i = 1'b0;
  logic lp_mode_wr_i = 1'b0, samp_wr_i = 1'b0, samp_data_i = 1'b0, cfg_wr_i = 1'b0, flag_clr_i = 1'b0;
  logic [7:0] key_data_i = 8'h00;
  logic [7:0] vdd = 8'hC8;
  logic [1:0] lp_mode_data_i = 2'h0;
  bmw_pkg::bmw_warn_cfg_t cfg_data_i = 5'h00;
  logic drop_below_i, warn_below_i, det_on_o, wake_hold_o, reset_req_o, samp_slow_o;
  logic warning_flag_o, warning_state_o, irq_o;
  logic [2:0] det_level_o;
  logic [1:0] warn_margin_o, awake_mode_o, lowpower_mode_o;
  bmw_pkg::bmw_warn_cfg_t cfg_o;
  int n_mismatch = 0;
  int tests_run = 0;
  int n;
  always #4 clk_i = ~clk_i;
  bmw_ctrl #(.SAMP_FAST_CYC(8), .SAMP_SLOW_CYC(16)) u_dut (.clk_i, .nrst_i, .fuse_i, .sleep_i, .dbg_halt_i,
    .key_wr_i, .key_data_i, .instr_i, .lp_mode_wr_i, .lp_mode_data_i, .samp_wr_i, .samp_data_i, .cfg_wr_i,
    .cfg_data_i, .flag_clr_i, .drop_below_i, .warn_below_i, .det_on_o, .det_level_o, .warn_margin_o,
    .wake_hold_o, .reset_req_o, .awake_mode_o, .lowpower_mode_o, .samp_slow_o, .cfg_o, .warning_flag_o,
    .warning_state_o, .irq_o);
  bmw_supply_model u_sup (.clk_i, .det_on_i(det_on_o), .vdd_i(vdd), .drop_below_o(drop_below_i),
    .warn_below_o(warn_below_i));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string m);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge clk_i);
  endtask
  // one-cycle write strobe, then an idle cycle so strobes never merge
  task automatic pulse(ref logic s);
    s = 1'b1;
    cyc(1);
    s = 1'b0;
    cyc(1);
  endtask
  task automatic count_on(input int k);
    n = 0;
    repeat (k) begin
      @(posedge clk_i);
      #1 n += int'(det_on_o);
    end
    @(negedge clk_i);
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic t_fuse;
    chk(8'(det_level_o), 8'h05, "level load");
    chk(8'(awake_mode_o), 8'h01, "awake load");
    chk(8'(lowpower_mode_o), 8'h00, "sleep load");
    chk(8'(cfg_o), 8'h00, "cfg reset");
    chk(8'(det_on_o), 8'h01, "continuous on");
    fuse_i = 8'h4E;
    cyc(2);
    chk(8'(det_level_o), 8'h05, "level fixed");
    chk(8'(awake_mode_o), 8'h01, "awake fixed");
    $display("done fuse");
  endtask
  task automatic t_unlock;
    lp_mode_data_i = bmw_pkg::BMW_MODE_SAMP;
    pulse(lp_mode_wr_i);
    chk(8'(lowpower_mode_o), 8'h00, "write w/o key");
    key_data_i = 8'h11;
    pulse(key_wr_i);
    pulse(lp_mode_wr_i);
    chk(8'(lowpower_mode_o), 8'h00, "wrong key");
    key_data_i = bmw_pkg::BMW_UNLOCK_KEY;
    pulse(key_wr_i);
    repeat (5) pulse(instr_i);
    pulse(lp_mode_wr_i);
    chk(8'(lowpower_mode_o), 8'h00, "window expired");
    pulse(key_wr_i);
    repeat (3) pulse(instr_i);
    pulse(lp_mode_wr_i);
    chk(8'(lowpower_mode_o), 8'h02, "unlocked write");
    $display("done unlock");
  endtask
  task automatic t_warn;
    cfg_data_i = '{margin: 2'h1, trig: 2'h0, irq_en: 1'b1};
    for (int t = 0; t < 3; t++) begin
      cfg_data_i.trig = 2'(t);
      pulse(cfg_wr_i);
      chk(8'(cfg_o), 8'(cfg_data_i), "cfg write");
      chk(8'(warn_margin_o), 8'h01, "margin out");
      vdd = 8'h78;
      cyc(3);
      chk(8'(warning_state_o), 8'h01, "state below");
      chk(8'(warning_flag_o), 8'(t != 1), "flag falling");
      chk(8'(irq_o), 8'(t != 1), "irq falling");
      pulse(flag_clr_i);
      vdd = 8'hC8;
      cyc(3);
      chk(8'(warning_state_o), 8'h00, "state above");
      chk(8'(warning_flag_o), 8'(t != 0), "flag rising");
      pulse(flag_clr_i);
      chk(8'(warning_flag_o), 8'h00, "flag cleared");
    end
    vdd = 8'h78;
    cyc(3);
    dbg_halt_i = 1'b1;
    cyc(1);
    chk(8'(irq_o), 8'h00, "irq held in halt");
    dbg_halt_i = 1'b0;
    cyc(1);
    chk(8'(irq_o), 8'h01, "irq after halt");
    vdd = 8'hC8;
    cyc(3);
    pulse(flag_clr_i);
    chk(8'(irq_o), 8'h00, "irq cleared");
    $display("done warn");
  endtask
  task automatic t_sleep;
    int seen_on;
    sleep_i = 1'b1;
    cyc(2);
    count_on(32);
    chk(8'(n), 8'h04, "fast strobes");
    vdd = 8'h78;
    seen_on = 0;
    repeat (10) begin
      seen_on |= int'(det_on_o);
      cyc(1);
      chk(8'(warning_flag_o), 8'(seen_on), "flag on sample only");
    end
    chk(8'(seen_on), 8'h01, "a sample came");
    vdd = 8'hC8;
    cyc(10);
    pulse(flag_clr_i);
    chk(8'(warning_flag_o), 8'h00, "sampled flag cleared");
    samp_data_i = 1'b1;
    pulse(samp_wr_i);
    chk(8'(samp_slow_o), 8'h01, "slow select");
    count_on(32);
    chk(8'(n), 8'h02, "slow strobes");
    sleep_i = 1'b0;
    lp_mode_data_i = bmw_pkg::BMW_MODE_DIS;
    pulse(key_wr_i);
    pulse(lp_mode_wr_i);
    sleep_i = 1'b1;
    vdd = 8'h50;
    cyc(2);
    count_on(8);
    chk(8'(n), 8'h00, "off in sleep");
    chk(8'(reset_req_o), 8'h00, "no reset off");
    chk(8'(warning_flag_o), 8'h00, "flag held off");
    sleep_i = 1'b0;
    cyc(2);
    chk(8'(det_on_o), 8'h01, "awake mode back");
    chk(8'(reset_req_o), 8'h01, "drop reset");
    vdd = 8'hC8;
    $display("done sleep");
  endtask
  task automatic t_wake;
    fuse_i = 8'h5D;
    nrst_i = 1'b0;
    cyc(3);
    nrst_i = 1'b1;
    cyc(1);
    chk(8'(det_level_o), 8'h02, "level reload");
    chk(8'(awake_mode_o), 8'h03, "awake reload");
    chk(8'(lowpower_mode_o), 8'h01, "sleep reload");
    chk(8'(samp_slow_o), 8'h01, "rate reload");
    chk(8'(warning_flag_o), 8'h00, "flag reset");
    chk(8'(irq_o), 8'h00, "irq reset");
    chk(8'(wake_hold_o), 8'h00, "no hold yet");
    sleep_i = 1'b1;
    cyc(2);
    chk(8'(det_on_o), 8'h01, "sleep continuous");
    sleep_i = 1'b0;
    cyc(1);
    chk(8'(wake_hold_o), 8'h01, "hold on wake");
    chk(8'(det_on_o), 8'h01, "awake continuous");
    cyc(1);
    chk(8'(wake_hold_o), 8'h00, "hold one cycle");
    $display("done wake");
  endtask
  initial begin
    cyc(3);
    nrst_i = 1'b1;
    cyc(1);
    t_fuse();
    t_unlock();
    t_warn();
    t_sleep();
    t_wake();
    final_report();
  end
  initial begin
    #200000;
    n_mismatch++;
    final_report();
  end
endmodule
`default_nettype wire
